// ---- src/gcj_global_control.sv ----
// global control and jitter attenuator configuration register bank
`timescale 1ns/1ps

// Notes on behaviour
// - identity byte reads variant and revision, read-only
// - reset bit reads one during any reset
// - reset ends within 15 us, defaults restored
// - after reset, bus outputs off, pins inputs
// - reserved bits written zero and ignored
// - E1 mode uses upper three mode bits
// - T1 mode decodes the listed codes
// - mode feeds reframe and loss criteria
// - rate bit picks E1 or T1 rate
// - reference chosen from free bit, rate adapter enable, direction bit
// - dejittered clock runs at selected line rate
// - free run opens loop, acceleration and phase detector error still active
// - direction picks path and clock output pin
// - near limit, phase shifts in 5 ns steps
// - each acceleration reported as clock error
// - recenter on write of one then zero
// - limit error recenters elastic store automatically
// - depth field selects 8 to 128 bits
module gcj_global_control
  import gcj_pkg::*;
(
  input  wire logic       clk_sys,            // system clock, 25 MHz
  input  wire logic       reset,              // asynchronous, active high
  input  wire logic       hw_reset_n,         // hardware reset pin, async
  input  wire gcj_req_s   host_req,           // host register access
  output logic      [7:0] host_rdata,         // read data, registered
  input  wire logic       rate_adapter_enable,// rate adapter on
  input  wire logic       store_near_over,    // depth within 1 UI of overflow
  input  wire logic       store_near_under,   // depth within 1 UI of under-run
  input  wire logic [2:0] store_proximity,    // proximity in 0.125 UI steps
  input  wire logic       elastic_limit_error,// store limit error pulse
  output logic            reset_active,       // reset in progress
  output gcj_mode_e       rx_framer_mode,     // decoded framer mode
  output logic      [3:0] framer_mode_raw,    // raw field for criteria logic
  output logic            line_rate_select,   // 1 T1, 0 E1
  output gcj_jat_s        jat_ctrl,           // decoded jitter controls
  output logic            accel_up,           // raise clock frequency
  output logic            accel_down,         // lower clock frequency
  output logic      [5:0] phase_shift_ns,     // accel phase shift in ns
  output logic            clock_error_flag,   // pulse per acceleration
  output logic            phase_detector_error,// acceleration status level
  output logic            recenter_pulse,     // recenter the store
  output logic            bus_outputs_enable, // system bus outputs driven
  output logic            interrupt_enable,   // interrupt output allowed
  output logic            prog_pins_output    // programmable pins drive
);

  // ==========================================================================
  // state
  typedef struct packed {
    gcj_state_e state;
    logic [8:0] count;       // reset duration counter
    logic [7:0] primary;     // primary control storage
    logic [7:0] jitter;      // jitter config storage
    logic       ctr_armed;   // recenter bit has been written one
    logic       ctr_pulse;
    logic       accel_up;
    logic       accel_down;
    logic [5:0] shift;
    logic       clk_err;
    logic       pd_err;
    logic [7:0] rdata;
    logic [2:0] hw_sync;     // hardware reset pin synchroniser
  } gcj_st_s;

  gcj_st_s st;
  gcj_st_s next_st;

  localparam logic [8:0] RST_LAST = 9'(GCJ_RESET_CYCLES - 1);

  logic hw_asserted;         // pin seen low by the agreeing stages
  logic rst_bit_wr;          // host writes one to the reset bit
  logic wr_primary;
  logic wr_jitter;

  assign hw_asserted = ~st.hw_sync[1] & ~st.hw_sync[2];
  assign wr_primary  = host_req.wr && host_req.addr == GCJ_ADDR_PRIMARY;
  assign wr_jitter   = host_req.wr && host_req.addr == GCJ_ADDR_JITTER;
  // zero-to-one write on the reset bit, ignored while resetting
  assign rst_bit_wr  = wr_primary && host_req.wdata[GCJ_PC_RESET_BIT]
                       && !st.primary[GCJ_PC_RESET_BIT] && st.state == GCJ_ST_IDLE;

  // ==========================================================================
  // next state
  always_comb begin
    next_st           = st;
    next_st.hw_sync   = {st.hw_sync[1:0], hw_reset_n};
    next_st.ctr_pulse = 1'b0;
    next_st.clk_err   = 1'b0;
    // reset sequencer
    unique case (st.state)
      GCJ_ST_IDLE: begin
        if (hw_asserted || rst_bit_wr) begin
          next_st.state = GCJ_ST_RESET;
          next_st.count = '0;
        end
      end
      GCJ_ST_RESET: begin
        // defaults restored throughout, ends after 15 us
        next_st.primary = GCJ_PC_RESET_VAL;
        next_st.jitter  = GCJ_JC_RESET_VAL;
        next_st.ctr_armed = 1'b0;  // recenter bit reads zero again, no stale arm
        if (hw_asserted) begin
          next_st.count = '0;
        end else if (st.count == RST_LAST) begin
          next_st.state = GCJ_ST_IDLE;
        end else begin
          next_st.count = st.count + 9'h001;
        end
      end
    endcase
    // register writes, reserved bits dropped, identity ignored
    if (st.state == GCJ_ST_IDLE && !hw_asserted) begin
      if (wr_primary) begin
        next_st.primary = host_req.wdata & GCJ_PC_WMASK;
        next_st.primary[GCJ_PC_RESET_BIT] = host_req.wdata[GCJ_PC_RESET_BIT];
      end
      if (wr_jitter) begin
        next_st.jitter = host_req.wdata & GCJ_JC_WMASK;
      end
    end
    // recenter on one then zero or on limit error
    if (wr_jitter && st.state == GCJ_ST_IDLE && !hw_asserted) begin
      if (host_req.wdata[GCJ_JC_CTR_BIT]) begin
        next_st.ctr_armed = 1'b1;
      end else if (st.ctr_armed) begin
        next_st.ctr_armed = 1'b0;
        next_st.ctr_pulse = 1'b1;
      end
    end
    if (elastic_limit_error) begin
      next_st.ctr_pulse = 1'b1;
    end
    // acceleration near the store limits
    next_st.accel_up   = st.jitter[GCJ_JC_ACC_BIT] && store_near_over;
    next_st.accel_down = st.jitter[GCJ_JC_ACC_BIT] && store_near_under && !store_near_over;
    if (next_st.accel_up || next_st.accel_down) begin
      next_st.shift = 6'(({3'h0, store_proximity} + 6'h01) * GCJ_PHASE_STEP_NS);
    end else begin
      next_st.shift = '0;
    end
    next_st.clk_err = (next_st.accel_up && !st.accel_up)
                      || (next_st.accel_down && !st.accel_down);
    next_st.pd_err  = next_st.accel_up || next_st.accel_down;
    // read data, reset bit live identity fixed
    next_st.rdata = 8'h00;
    if (host_req.rd) begin
      unique case (host_req.addr)
        GCJ_ADDR_IDENTITY: next_st.rdata = {GCJ_VARIANT_ID, GCJ_REVISION_ID};
        GCJ_ADDR_PRIMARY: begin
          next_st.rdata = st.primary & GCJ_PC_WMASK;
          next_st.rdata[GCJ_PC_RESET_BIT] = (st.state == GCJ_ST_RESET);
        end
        GCJ_ADDR_JITTER:  next_st.rdata = st.jitter;
        default:          next_st.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // state register, power-on reset counts as a reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st         <= '0;
      st.state   <= GCJ_ST_RESET;
      st.primary <= GCJ_PC_RESET_VAL;
      st.jitter  <= GCJ_JC_RESET_VAL;
      st.hw_sync <= 3'h7;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // framer mode decode
  always_comb begin
    framer_mode_raw = st.primary[GCJ_PC_MODE_LSB +: 4];
    if (!st.primary[GCJ_PC_RATE_BIT]) begin
      rx_framer_mode = gcj_mode_e'({1'b0, framer_mode_raw[3:1]});
    end else begin
      unique case (framer_mode_raw)
        4'h0:    rx_framer_mode = GCJ_FM_T1_FT;
        4'h1:    rx_framer_mode = GCJ_FM_T1_ESF_NOCRC;
        4'h4:    rx_framer_mode = GCJ_FM_T1_SF;
        4'h5:    rx_framer_mode = GCJ_FM_T1_SF_YEL;
        4'h6:    rx_framer_mode = GCJ_FM_T1_SF_DM;
        4'h8:    rx_framer_mode = GCJ_FM_T1_CARRIER;
        4'h9:    rx_framer_mode = GCJ_FM_T1_CARRIER;
        4'hC:    rx_framer_mode = GCJ_FM_T1_ESF_MIMIC;
        4'hD:    rx_framer_mode = GCJ_FM_T1_ESF_FORCE;
        default: rx_framer_mode = GCJ_FM_T1_FT;
      endcase
    end
  end

  // ==========================================================================
  // jitter attenuator decode
  always_comb begin
    jat_ctrl = '0;
    if (st.jitter[GCJ_JC_FREE_BIT]) begin
      jat_ctrl.ref_sel = GCJ_REF_FREE_RUN;
    end else if (rate_adapter_enable) begin
      jat_ctrl.ref_sel = GCJ_REF_ADAPTER;
    end else if (st.jitter[GCJ_JC_DIR_BIT]) begin
      jat_ctrl.ref_sel = GCJ_REF_RX_CLOCK;
    end else begin
      jat_ctrl.ref_sel = GCJ_REF_TX_CLOCK;
    end
    jat_ctrl.bypass_store = rate_adapter_enable && !st.jitter[GCJ_JC_EN_BIT];
    jat_ctrl.open_loop    = st.jitter[GCJ_JC_FREE_BIT];
    jat_ctrl.rx_path      = st.jitter[GCJ_JC_EN_BIT] && st.jitter[GCJ_JC_DIR_BIT];
    jat_ctrl.tx_clk_drive = st.jitter[GCJ_JC_EN_BIT] && !st.jitter[GCJ_JC_DIR_BIT];
    jat_ctrl.rx_clk_drive = jat_ctrl.rx_path;
    unique case (st.jitter[GCJ_JC_SIZE_LSB +: 3])
      3'h0:    jat_ctrl.depth_bits = 8'h08;
      3'h1:    jat_ctrl.depth_bits = 8'h10;
      3'h2:    jat_ctrl.depth_bits = 8'h20;
      3'h3:    jat_ctrl.depth_bits = 8'h40;
      default: jat_ctrl.depth_bits = 8'h80;
    endcase
  end

  // ==========================================================================
  // outputs; rate bit sets line rate, clock follows it
  assign host_rdata           = st.rdata;
  assign reset_active         = (st.state == GCJ_ST_RESET);
  assign line_rate_select     = st.primary[GCJ_PC_RATE_BIT];
  assign accel_up             = st.accel_up;
  assign accel_down           = st.accel_down;
  assign phase_shift_ns       = st.shift;
  assign clock_error_flag     = st.clk_err;
  assign phase_detector_error = st.pd_err;
  assign recenter_pulse       = st.ctr_pulse;
  // outputs held off, tied to zero in this block
  assign bus_outputs_enable   = 1'b0;
  assign interrupt_enable     = 1'b0;
  assign prog_pins_output     = 1'b0;

  // ==========================================================================
  // assertions
  property p_reset_len;
    @(posedge clk_sys) disable iff (reset)
      ($rose(reset_active) && !hw_asserted) |-> reset_active [*8];
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("reset too short");

  property p_reset_end;
    @(posedge clk_sys) disable iff (reset || hw_asserted)
      $rose(reset_active) |-> ##[1:380] !reset_active;
  endproperty
  a_reset_end: assert property (p_reset_end) else $error("reset too long");

  property p_defaults;
    @(posedge clk_sys) disable iff (reset)
      $fell(reset_active) |-> (st.primary == GCJ_PC_RESET_VAL && st.jitter == GCJ_JC_RESET_VAL);
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults lost");

  property p_rbit;
    @(posedge clk_sys) disable iff (reset)
      (host_req.rd && host_req.addr == GCJ_ADDR_PRIMARY)
        |=> host_rdata[7] == $past(reset_active);
  endproperty
  a_rbit: assert property (p_rbit) else $error("reset bit wrong");

  property p_ident;
    @(posedge clk_sys) disable iff (reset)
      (host_req.rd && host_req.addr == GCJ_ADDR_IDENTITY)
        |=> host_rdata == {GCJ_VARIANT_ID, GCJ_REVISION_ID};
  endproperty
  a_ident: assert property (p_ident) else $error("identity wrong");

  property p_reserved;
    @(posedge clk_sys) disable iff (reset)
      st.primary[6:5] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_swreset;
    @(posedge clk_sys) disable iff (reset)
      rst_bit_wr |=> reset_active;
  endproperty
  a_swreset: assert property (p_swreset) else $error("no sw reset");

  property p_limit;
    @(posedge clk_sys) disable iff (reset)
      elastic_limit_error |=> recenter_pulse;
  endproperty
  a_limit: assert property (p_limit) else $error("no recenter");

  property p_clkerr;
    @(posedge clk_sys) disable iff (reset)
      clock_error_flag |-> (accel_up || accel_down) && phase_detector_error;
  endproperty
  a_clkerr: assert property (p_clkerr) else $error("clock error unmatched");

  property p_shift;
    @(posedge clk_sys) disable iff (reset)
      phase_shift_ns <= 6'(GCJ_PHASE_MAX_NS);
  endproperty
  a_shift: assert property (p_shift) else $error("shift too large");

  property p_write_refused;
    @(posedge clk_sys) disable iff (reset)
      (reset_active && wr_primary) |=> st.primary == GCJ_PC_RESET_VAL;
  endproperty
  a_write_refused: assert property (p_write_refused) else $error("write during reset");

  property p_center_wr;
    @(posedge clk_sys) disable iff (reset)
      (wr_jitter && !reset_active && !hw_asserted && st.ctr_armed
        && !host_req.wdata[GCJ_JC_CTR_BIT]) |=> recenter_pulse;
  endproperty
  a_center_wr: assert property (p_center_wr) else $error("no recenter on write");

  property p_accel_excl;
    @(posedge clk_sys) disable iff (reset)
      !(accel_up && accel_down);
  endproperty
  a_accel_excl: assert property (p_accel_excl) else $error("accel both ways");

  property p_depth;
    @(posedge clk_sys) disable iff (reset)
      $onehot(jat_ctrl.depth_bits) && jat_ctrl.depth_bits >= 8'h08;
  endproperty
  a_depth: assert property (p_depth) else $error("depth out of range");

  property p_rx_path;
    @(posedge clk_sys) disable iff (reset)
      jat_ctrl.rx_path |-> (jat_ctrl.rx_clk_drive && !jat_ctrl.tx_clk_drive);
  endproperty
  a_rx_path: assert property (p_rx_path) else $error("clock pin wrong");

  c_swreset: cover property (@(posedge clk_sys) disable iff (reset) rst_bit_wr ##1 reset_active);
  c_accel:   cover property (@(posedge clk_sys) disable iff (reset) $rose(accel_up));
  c_center:  cover property (@(posedge clk_sys) disable iff (reset) recenter_pulse);
  c_hwreset: cover property (@(posedge clk_sys) disable iff (reset) hw_asserted ##1 reset_active);

endmodule // gcj_global_control

// ---- src/gcj_pkg.sv ----
// package for the global control and jitter configuration register bank
package gcj_pkg;

  // ==========================================================================
  // register map
  localparam logic [8:0] GCJ_ADDR_IDENTITY = 9'h000;
  localparam logic [8:0] GCJ_ADDR_PRIMARY  = 9'h001;
  localparam logic [8:0] GCJ_ADDR_JITTER   = 9'h002;

  // ==========================================================================
  // field positions
  localparam int GCJ_PC_RESET_BIT = 7;
  localparam int GCJ_PC_MODE_LSB  = 1;
  localparam int GCJ_PC_RATE_BIT  = 0;
  localparam int GCJ_JC_EN_BIT    = 7;
  localparam int GCJ_JC_FREE_BIT  = 6;
  localparam int GCJ_JC_DIR_BIT   = 5;
  localparam int GCJ_JC_ACC_BIT   = 4;
  localparam int GCJ_JC_CTR_BIT   = 3;
  localparam int GCJ_JC_SIZE_LSB  = 0;

  // writable masks, reserved bits dropped
  localparam logic [7:0] GCJ_PC_WMASK = 8'h1F;
  localparam logic [7:0] GCJ_JC_WMASK = 8'hFF;

  // ==========================================================================
  // reset values
  localparam logic [7:0] GCJ_PC_RESET_VAL = 8'h00;
  localparam logic [7:0] GCJ_JC_RESET_VAL = 8'h00;

  // identity codes, values arbitrary
  localparam logic [3:0] GCJ_VARIANT_ID  = 4'hA;
  localparam logic [3:0] GCJ_REVISION_ID = 4'h3;

  // ==========================================================================
  // timing
  localparam int GCJ_CLK_MHZ        = 25;
  localparam int GCJ_RESET_TIME_US  = 15;
  localparam int GCJ_RESET_CYCLES   = GCJ_RESET_TIME_US * GCJ_CLK_MHZ;
  localparam int GCJ_PHASE_STEP_NS  = 5;
  localparam int GCJ_PHASE_MAX_NS   = 40;
  localparam int GCJ_PHASE_STEPS    = GCJ_PHASE_MAX_NS / GCJ_PHASE_STEP_NS;

  // ==========================================================================
  // modes
  typedef enum logic [1:0] {
    GCJ_REF_FREE_RUN,
    GCJ_REF_TX_CLOCK,
    GCJ_REF_RX_CLOCK,
    GCJ_REF_ADAPTER
  } gcj_ref_e;

  typedef enum logic [3:0] {
    GCJ_FM_E1_FAS, GCJ_FM_E1_FAS_SLIP, GCJ_FM_E1_CRC, GCJ_FM_E1_CRC_SLIP,
    GCJ_FM_E1_CAS, GCJ_FM_E1_CAS_SLIP, GCJ_FM_E1_CRC_CAS, GCJ_FM_E1_ALL,
    GCJ_FM_T1_FT, GCJ_FM_T1_ESF_NOCRC, GCJ_FM_T1_SF, GCJ_FM_T1_SF_YEL,
    GCJ_FM_T1_SF_DM, GCJ_FM_T1_CARRIER, GCJ_FM_T1_ESF_MIMIC, GCJ_FM_T1_ESF_FORCE
  } gcj_mode_e;

  // host port request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [8:0] addr;
    logic [7:0] wdata;
  } gcj_req_s;

  // decoded jitter attenuator controls
  typedef struct packed {
    gcj_ref_e   ref_sel;
    logic       bypass_store;
    logic       open_loop;
    logic       rx_path;
    logic       tx_clk_drive;
    logic       rx_clk_drive;
    logic [7:0] depth_bits;
  } gcj_jat_s;

  typedef enum logic [1:0] { GCJ_ST_IDLE, GCJ_ST_RESET } gcj_state_e;

endpackage : gcj_pkg

// ---- bench/gcj_host_model.sv ----
// host processor model for the register port of the global control bank
`timescale 1ns/1ps

module gcj_host_model
  import gcj_pkg::*;
(
  input  wire logic       clk_sys,   // system clock
  output gcj_req_s        host_req,  // register request
  input  wire logic [7:0] host_rdata // read data
);
  // ==========================================================================
  // bus cycles
  initial host_req = '0;

  // read: strobe for one edge, data lands the cycle after
  task automatic read(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    host_req <= '0;
    #1 d = host_rdata;
  endtask

  // raw write: no reset wait, no masking
  task automatic write_raw(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_sys);
    host_req <= '0;
  endtask

  // polite write: waits out a reset, reserved bits kept at zero
  task automatic write(input logic [8:0] a, input logic [7:0] d);
    logic [7:0] s;
    s = 8'h80;
    for (int i = 0; i < 1000 && s[7] !== 1'b0; i++) read(GCJ_ADDR_PRIMARY, s);
    if (a == GCJ_ADDR_PRIMARY) d[6:5] = 2'b00;
    write_raw(a, d);
  endtask

  // software reset: clear the bit, hold off 6 us, then set it
  task automatic soft_reset(input logic [4:0] keep);
    write(GCJ_ADDR_PRIMARY, {3'b000, keep});
    repeat (150) @(posedge clk_sys);
    write(GCJ_ADDR_PRIMARY, {3'b100, keep});
  endtask
endmodule // gcj_host_model

// ---- bench/tb_top.sv ----
// self-checking testbench for the global control register bank
`timescale 1ns/1ps
`define check_eq(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module tb_top
  import gcj_pkg::*;
;
  // ==========================================================================
  // signals
  logic        clk_sys, reset, hw_reset_n, rate_adapter_enable;
  logic        store_near_over, store_near_under, elastic_limit_error;
  logic [2:0]  store_proximity;
  gcj_req_s    host_req;
  logic [7:0]  host_rdata, d;
  logic        reset_active, line_rate_select, accel_up, accel_down;
  logic        clock_error_flag, phase_detector_error, recenter_pulse;
  logic        bus_outputs_enable, interrupt_enable, prog_pins_output;
  gcj_mode_e   rx_framer_mode;
  logic [3:0]  framer_mode_raw;
  gcj_jat_s    jat_ctrl;
  logic [5:0]  phase_shift_ns;
  logic [31:0] rv;
  integer      seed;
  int          miscompares = 0, checks = 0, n, ce_cnt = 0, rc_cnt = 0, ce_b, rc_b;

  // ==========================================================================
  // instances
  gcj_global_control gcj_global_control_i (.clk_sys(clk_sys), .reset(reset),
    .hw_reset_n(hw_reset_n), .host_req(host_req), .host_rdata(host_rdata),
    .rate_adapter_enable(rate_adapter_enable), .store_near_over(store_near_over),
    .store_near_under(store_near_under), .store_proximity(store_proximity),
    .elastic_limit_error(elastic_limit_error), .reset_active(reset_active),
    .rx_framer_mode(rx_framer_mode), .framer_mode_raw(framer_mode_raw),
    .line_rate_select(line_rate_select), .jat_ctrl(jat_ctrl), .accel_up(accel_up),
    .accel_down(accel_down), .phase_shift_ns(phase_shift_ns),
    .clock_error_flag(clock_error_flag), .phase_detector_error(phase_detector_error),
    .recenter_pulse(recenter_pulse), .bus_outputs_enable(bus_outputs_enable),
    .interrupt_enable(interrupt_enable), .prog_pins_output(prog_pins_output));
  gcj_host_model host_i (.clk_sys(clk_sys), .host_req(host_req), .host_rdata(host_rdata));

  // ==========================================================================
  // clock, pulse counters, expectations
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // count one-cycle pulses from the block
  always @(posedge clk_sys) begin
    if (clock_error_flag === 1'b1) ce_cnt++;
    if (recenter_pulse === 1'b1) rc_cnt++;
  end

  // framer mode from field and rate bit
  function automatic gcj_mode_e exp_mode(input logic [3:0] m, input logic t1);
    if (!t1) return gcj_mode_e'({1'b0, m[3:1]});
    case (m)
      4'h1: return GCJ_FM_T1_ESF_NOCRC;
      4'h4: return GCJ_FM_T1_SF;
      4'h5: return GCJ_FM_T1_SF_YEL;
      4'h6: return GCJ_FM_T1_SF_DM;
      4'h8, 4'h9: return GCJ_FM_T1_CARRIER;
      4'hC: return GCJ_FM_T1_ESF_MIMIC;
      4'hD: return GCJ_FM_T1_ESF_FORCE;
      default: return GCJ_FM_T1_FT;
    endcase
  endfunction

  // reference from {adapter, enable, free, direction}
  function automatic gcj_ref_e exp_ref(input logic [3:0] j);
    if (j[1]) return GCJ_REF_FREE_RUN;
    if (j[3]) return GCJ_REF_ADAPTER;
    return j[0] ? GCJ_REF_RX_CLOCK : GCJ_REF_TX_CLOCK;
  endfunction

  // bounded wait for the reset sequencer to finish
  task automatic wait_done(output int c);
    c = 0;
    while (reset_active !== 1'b0 && c < 2000) begin
      @(posedge clk_sys);
      c++;
    end
  endtask

  // verdict and end of run
  task automatic end_of_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog, far beyond the fewer than two thousand cycles needed
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    end_of_test;
  end

  // ==========================================================================
  // main sequence
  initial begin
    seed = 30;
    {reset, hw_reset_n, rate_adapter_enable} = 3'b110;
    {store_near_over, store_near_under, elastic_limit_error, store_proximity} = '0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1 `check_eq(reset_active, 1'b1)
    host_i.read(GCJ_ADDR_PRIMARY, d);
    `check_eq(d[7], 1'b1)
    wait_done(n);
    `check_eq(n <= GCJ_RESET_CYCLES, 1'b1)
    `check_eq({bus_outputs_enable, interrupt_enable, prog_pins_output}, 3'b000)
    // identity is read-only, unmapped reads zero
    host_i.write(GCJ_ADDR_IDENTITY, 8'h5C);
    host_i.read(GCJ_ADDR_IDENTITY, d);
    `check_eq(d, {GCJ_VARIANT_ID, GCJ_REVISION_ID})
    host_i.read(9'h003, d);
    `check_eq(d, 8'h00)
    // every mode code at both rates, random junk in reserved bits
    for (int i = 0; i < 32; i++) begin
      rv = $random(seed);
      host_i.write_raw(GCJ_ADDR_PRIMARY, {1'b0, rv[1:0], i[4:0]});
      host_i.read(GCJ_ADDR_PRIMARY, d);
      `check_eq(d, {3'b000, i[4:0]})
      `check_eq(line_rate_select, i[0])
      `check_eq(framer_mode_raw, i[4:1])
      `check_eq(rx_framer_mode, exp_mode(i[4:1], i[0]))
    end
    // jitter settings rewritten after the rate change; acceleration off here
    for (int j = 0; j < 16; j++) begin
      @(posedge clk_sys);
      rv = $random(seed);
      if (!j[3]) rv[2:0] = j[2:0]; // every depth code once, then random
      rate_adapter_enable <= j[3];
      host_i.write(GCJ_ADDR_JITTER, {j[2:0], 2'b00, rv[2:0]});
      host_i.read(GCJ_ADDR_JITTER, d);
      `check_eq(d, {j[2:0], 2'b00, rv[2:0]})
      if (j[3:1] != 3'b000) `check_eq(jat_ctrl.ref_sel, exp_ref(j[3:0]))
      `check_eq(jat_ctrl.bypass_store, j[3] & ~j[2])
      `check_eq(jat_ctrl.open_loop, j[1])
      `check_eq({jat_ctrl.tx_clk_drive, jat_ctrl.rx_clk_drive}, {j[2] & ~j[0], j[2] & j[0]})
      `check_eq(jat_ctrl.rx_path, j[2] & j[0])
      `check_eq(jat_ctrl.depth_bits, rv[2] ? 8'h80 : 8'h08 << rv[1:0])
    end
    // acceleration both ways, full-scale proximity first
    @(posedge clk_sys);
    rate_adapter_enable <= 1'b0;
    host_i.write(GCJ_ADDR_JITTER, 8'h92);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      rv = (k == 0) ? 32'h7 : $random(seed);
      ce_b = ce_cnt;
      store_proximity <= rv[2:0];
      store_near_over <= ~k[0];
      store_near_under <= k[0];
      repeat (3) @(posedge clk_sys);
      #1 `check_eq({accel_up, accel_down}, k[0] ? 2'b01 : 2'b10)
      `check_eq(phase_shift_ns, 6'((rv[2:0] + 1) * GCJ_PHASE_STEP_NS))
      `check_eq(phase_detector_error, 1'b1)
      @(posedge clk_sys);
      {store_near_over, store_near_under} <= 2'b00;
      repeat (3) @(posedge clk_sys);
      #1 `check_eq(ce_cnt - ce_b, 1)
    end
    // acceleration disabled: near limit is ignored
    host_i.write(GCJ_ADDR_JITTER, 8'h82);
    store_near_over <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 `check_eq({accel_up, accel_down}, 2'b00)
    @(posedge clk_sys);
    store_near_over <= 1'b0;
    // recenter by one-then-zero, then by a limit error
    rc_b = rc_cnt;
    host_i.write(GCJ_ADDR_JITTER, 8'h8A);
    host_i.write(GCJ_ADDR_JITTER, 8'h82);
    repeat (3) @(posedge clk_sys);
    `check_eq(rc_cnt - rc_b, 1)
    @(posedge clk_sys);
    elastic_limit_error <= 1'b1;
    @(posedge clk_sys);
    elastic_limit_error <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `check_eq(rc_cnt - rc_b, 2)
    // software reset, with a repeated set ignored mid-sequence
    host_i.soft_reset(5'h1F);
    host_i.write_raw(GCJ_ADDR_PRIMARY, 8'h80);
    host_i.read(GCJ_ADDR_PRIMARY, d);
    `check_eq(d[7], 1'b1)
    wait_done(n);
    // four cycles already spent since the start; a restart would add two more
    `check_eq(n <= GCJ_RESET_CYCLES - 2, 1'b1)
    repeat (5) @(posedge clk_sys);
    `check_eq(reset_active, 1'b0)
    host_i.read(GCJ_ADDR_JITTER, d);
    `check_eq(d, GCJ_JC_RESET_VAL)
    host_i.read(GCJ_ADDR_PRIMARY, d);
    `check_eq(d, GCJ_PC_RESET_VAL)
    // hardware reset pin
    host_i.write(GCJ_ADDR_JITTER, 8'h82);
    @(posedge clk_sys);
    hw_reset_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    hw_reset_n <= 1'b1;
    #1 `check_eq(reset_active, 1'b1)
    wait_done(n);
    `check_eq(n <= GCJ_RESET_CYCLES + 3, 1'b1)
    host_i.read(GCJ_ADDR_JITTER, d);
    `check_eq(d, GCJ_JC_RESET_VAL)
    end_of_test;
  end
endmodule // tb_top
